// File: design/ied_dispatch.sv
// Purpose: interrupt and exception dispatch engine behind an APB slave
// Assumes: single 20 MHz clock pclk, asynchronous active-low presetn
// Notes:   stack is a 16-word window indexed by stack_pointer[5:2]
//
// Operation
// - entry through an interrupt gate clears the interrupt enable flag
// - entry through a trap gate leaves the interrupt enable flag alone
// - same level keeps current stack; more privileged level takes its stack
// - without stack change push flags, code selector, pointer, then enter
// - error code pushed after return state, before flag clear and entry
// - stack change saves five old values onto new stack, then error code
// - gate gives rights, handler selector and entry offset used to enter
// - return from interrupt also restores the status flags register
// - same-level return restores pointer, selector, flags, moves pointer up
// - cross-level return checks privilege, restores five values, old stack
// - task gate switches task and saves whole interrupted state
// - return from handler task restores the interrupted state
// - real mode indexes handler table by vector and far-calls the entry
// - real mode saves flags, selector, pointer, error code before entry
// - software interrupt dispatches to any vector given as operand
// - overflow trap raises vector 4 only when overflow flag is set
// - arithmetic overflow sets the flag but never raises an exception
// - breakpoint instruction dispatches straight to the breakpoint handler
// - range check raises vector 5 when operand is out of bounds
// - no bounds check or range exception except by those instructions
// - vectors 32 to 255 are maskable user interrupts
`timescale 1ns/1ps
`default_nettype none
`include "ied_defines.svh"

module ied_dispatch (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb request
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  // apb answer
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr
);

  // ***********************************************************************
  // state
  // ***********************************************************************
  ied_pkg::ied_regs_t r;
  ied_pkg::ied_regs_t next_r;

  logic        setup;
  logic        acc_wr;
  logic        hit;
  logic [31:0] rdat;
  logic        busy;
  logic        cmd_wr;
  ied_pkg::ied_op_t op;
  logic [7:0]  v;
  logic        go;
  logic        sw;
  logic [2:0]  g;
  logic [31:0] w;
  logic [31:0] nsp;
  logic [32:0] sum;

  // outputs straight from flops
  assign prdata  = r.prdata;
  assign pready  = r.pready;
  assign pslverr = r.pslverr;

  // ***********************************************************************
  // frame word selector
  // ***********************************************************************
  function automatic logic [31:0] frame_word(input ied_pkg::ied_regs_t s);
    logic [31:0] f;
    f = s.err;
    unique case (s.k)
      `IED_K_SS:    f = s.oss;
      `IED_K_SP:    f = s.osp;
      `IED_K_FLAGS: f = s.oflags;
      `IED_K_CS:    f = s.ocs;
      `IED_K_IP:    f = s.oip;
      default:      f = s.err;
    endcase
    return f;
  endfunction : frame_word

  // ***********************************************************************
  // next state
  // ***********************************************************************
  always_comb begin
    next_r = r;
    setup  = psel & ~penable & ~r.pready;
    acc_wr = psel & penable & r.pready & pwrite & ~r.pslverr;
    busy   = (r.st != ied_pkg::IED_IDLE);
    hit    = 1'b0;
    rdat   = 32'h0000_0000;
    op     = ied_pkg::ied_op_t'(pwdata[`IED_CMD_OP_LSB +: 3]);
    v      = pwdata[7:0];
    go     = 1'b0;
    sw     = 1'b0;
    g      = 3'h0;
    w      = r.stk[r.sp[5:2]];
    nsp    = r.sp - `IED_WORD_BYTES;
    sum    = 33'h0_0000_0000;
    cmd_wr = acc_wr & (paddr == `IED_OFF_CMD);

    // read decode; gate table and stack window repeat per entry
    unique case (paddr)
      `IED_OFF_CMD:   rdat = {20'h0_0000, r.fault, r.masked, r.raised,
                              busy, r.vec};
      `IED_OFF_FLAGS: rdat = r.flags;
      `IED_OFF_IP:    rdat = r.ip;
      `IED_OFF_CS:    rdat = r.cs;
      `IED_OFF_SP:    rdat = r.sp;
      `IED_OFF_SS:    rdat = r.ss;
      `IED_OFF_ERR:   rdat = r.err;
      `IED_OFF_SP0:   rdat = r.sp0;
      `IED_OFF_SS0:   rdat = r.ss0;
      `IED_OFF_BLO:   rdat = r.blo;
      `IED_OFF_BHI:   rdat = r.bhi;
      `IED_OFF_OPND:  rdat = r.opnd;
      default:        rdat = 32'h0000_0000;
    endcase
    hit = (paddr <= `IED_OFF_OPND) & (paddr[1:0] == 2'h0);
    for (int i = 0; i < 8; i++) begin
      if (paddr == 8'(`IED_OFF_GATE + `IED_GATE_STEP * i)) begin
        rdat = r.goff[i];
        hit  = 1'b1;
      end
      if (paddr == 8'(`IED_OFF_GATE + `IED_GATE_STEP * i + 4)) begin
        rdat = {14'h0000, r.gtyp[i], r.gsel[i]};
        hit  = 1'b1;
      end
    end
    for (int i = 0; i < 16; i++) begin
      if (paddr == 8'(`IED_OFF_STK + 4 * i)) begin
        rdat = r.stk[i];
        hit  = 1'b1;
      end
    end

    // answer in the access phase; writes refused while a dispatch runs
    next_r.pready = setup;
    if (setup) begin
      next_r.prdata  = pwrite ? 32'h0000_0000 : rdat;
      next_r.pslverr = ~hit | (pwrite & busy);
    end else if (r.pready) begin
      next_r.pslverr = 1'b0;
      next_r.prdata  = 32'h0000_0000;
    end

    // plain register writes, only reachable while idle
    if (acc_wr) begin
      unique case (paddr)
        `IED_OFF_FLAGS: next_r.flags = pwdata;
        `IED_OFF_IP:    next_r.ip    = pwdata;
        `IED_OFF_CS:    next_r.cs    = pwdata;
        `IED_OFF_SP:    next_r.sp    = pwdata;
        `IED_OFF_SS:    next_r.ss    = pwdata;
        `IED_OFF_ERR:   next_r.err   = pwdata;
        `IED_OFF_SP0:   next_r.sp0   = pwdata;
        `IED_OFF_SS0:   next_r.ss0   = pwdata;
        `IED_OFF_BLO:   next_r.blo   = pwdata;
        `IED_OFF_BHI:   next_r.bhi   = pwdata;
        `IED_OFF_OPND:  next_r.opnd  = pwdata;
        default:        next_r.opnd  = r.opnd;
      endcase
      for (int i = 0; i < 8; i++) begin
        if (paddr == 8'(`IED_OFF_GATE + `IED_GATE_STEP * i))
          next_r.goff[i] = pwdata;
        if (paddr == 8'(`IED_OFF_GATE + `IED_GATE_STEP * i + 4)) begin
          next_r.gsel[i] = pwdata[15:0];
          next_r.gtyp[i] = pwdata[17:16];
        end
      end
      for (int i = 0; i < 16; i++) begin
        if (paddr == 8'(`IED_OFF_STK + 4 * i))
          next_r.stk[i] = pwdata;
      end
    end

    unique case (r.st)
      // command decode and dispatch start
      ied_pkg::IED_IDLE: begin
        if (cmd_wr) begin
          next_r.raised = 1'b0;
          next_r.masked = 1'b0;
          next_r.fault  = 1'b0;
          unique case (op)
            ied_pkg::OP_EVENT: begin
              // user vectors held off while enable is clear
              go = (v < `IED_VEC_USER) | r.flags[`IED_FLAG_IF];
              next_r.masked = ~go;
            end
            ied_pkg::OP_SOFT:  go = 1'b1;
            ied_pkg::OP_INTO: begin
              v  = `IED_VEC_OF;
              go = r.flags[`IED_FLAG_OF];
            end
            ied_pkg::OP_BREAK: begin
              v  = `IED_VEC_BP;
              go = 1'b1;
            end
            ied_pkg::OP_BOUND: begin
              // only place a bounds check is ever made
              v  = `IED_VEC_BR;
              go = ($signed(r.opnd) < $signed(r.blo)) |
                   ($signed(r.opnd) > $signed(r.bhi));
            end
            ied_pkg::OP_RETURN_FROM_INTERRUPT: begin
              next_r.oip = r.ip;
              next_r.ocs = r.cs;
              next_r.osp = r.sp;
              if (r.flags[`IED_FLAG_NT]) begin
                // back to the interrupted task
                next_r.flags = r.tflags;
                next_r.ip    = r.tip;
                next_r.cs    = r.tcs;
                next_r.sp    = r.tsp;
                next_r.ss    = r.tss;
              end else begin
                next_r.k  = `IED_K_IP;
                next_r.st = ied_pkg::IED_POP;
              end
            end
            ied_pkg::OP_ARITH: begin
              // overflow only flagged, never dispatched
              sum = {1'b0, r.opnd} + {1'b0, r.blo};
              next_r.opnd = sum[31:0];
              next_r.flags[`IED_FLAG_OF] =
                (r.opnd[31] == r.blo[31]) & (sum[31] != r.opnd[31]);
            end
            default: go = 1'b0;
          endcase
          if (go) begin
            g = v[2:0];
            next_r.vec    = v;
            next_r.raised = 1'b1;
            next_r.oflags = r.flags;
            next_r.ocs    = r.cs;
            next_r.oip    = r.ip;
            next_r.osp    = r.sp;
            next_r.oss    = r.ss;
            // error code only for events that carry one
            next_r.kend   = (pwdata[`IED_CMD_ERR] &
                             (op == ied_pkg::OP_EVENT)) ?
                            `IED_K_ERR : `IED_K_IP;
            if (pwdata[`IED_CMD_REAL]) begin
              // flat table of far pointers, three-word frame plus any error code
              next_r.igate = 1'b1;
              next_r.k     = `IED_K_FLAGS;
              next_r.st    = ied_pkg::IED_PUSH;
            end else if (r.gtyp[g] == `IED_GT_TASK) begin
              next_r.tflags = r.flags;
              next_r.tip    = r.ip;
              next_r.tcs    = r.cs;
              next_r.tsp    = r.sp;
              next_r.tss    = r.ss;
              next_r.cs     = {16'h0000, r.gsel[g]};
              next_r.ip     = r.goff[g];
              next_r.flags[`IED_FLAG_NT] = 1'b1;
            end else begin
              sw = r.gsel[g][1:0] < r.cs[1:0];
              next_r.igate = (r.gtyp[g] == `IED_GT_INT);
              if (sw) begin
                next_r.sp = r.sp0;
                next_r.ss = r.ss0;
              end
              next_r.k  = sw ? `IED_K_SS : `IED_K_FLAGS;
              next_r.st = ied_pkg::IED_PUSH;
            end
          end
        end
      end
      // one word per cycle; entry in the same cycle as the last word
      ied_pkg::IED_PUSH: begin
        next_r.sp = nsp;
        next_r.stk[nsp[5:2]] = frame_word(r);
        next_r.k = r.k + 3'h1;
        if (r.k == r.kend) begin
          next_r.st = ied_pkg::IED_IDLE;
          next_r.cs = {16'h0000, r.gsel[r.vec[2:0]]};
          next_r.ip = r.goff[r.vec[2:0]];
          if (r.igate)
            next_r.flags[`IED_FLAG_IF] = 1'b0;
        end
      end
      // unwind: pointer, selector, flags, then outer stack if needed
      ied_pkg::IED_POP: begin
        next_r.sp = r.sp + `IED_WORD_BYTES;
        next_r.k  = r.k - 3'h1;
        unique case (r.k)
          `IED_K_IP: next_r.ip = w;
          `IED_K_CS: begin
            if (w[1:0] < r.ocs[1:0]) begin
              // no return inward; undo and report
              next_r.fault = 1'b1;
              next_r.ip    = r.oip;
              next_r.sp    = r.osp;
              next_r.st    = ied_pkg::IED_IDLE;
            end else begin
              next_r.cs = w;
            end
          end
          `IED_K_FLAGS: begin
            next_r.flags = w;
            if (r.cs[1:0] == r.ocs[1:0])
              next_r.st = ied_pkg::IED_IDLE;
          end
          `IED_K_SP: next_r.osp = w;
          default: begin
            next_r.ss = w;
            next_r.sp = r.osp;
            next_r.st = ied_pkg::IED_IDLE;
          end
        endcase
      end
      default: next_r.st = ied_pkg::IED_IDLE;
    endcase
  end

  // ***********************************************************************
  // state register
  // ***********************************************************************
  // reset loads constants only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r       <= '0;
      r.st    <= ied_pkg::IED_IDLE;
      r.flags <= `IED_RST_FLAGS;
    end else begin
      r <= next_r;
    end
  end

endmodule : ied_dispatch
`default_nettype wire

// File: dv/ied_dispatch_bench.sv
// Purpose: self-checking bench of the dispatcher over its bus
// Assumes: zero wait slave, busy polled in the status word
// Notes:   stack words read back through the window
`timescale 1ns/1ps
`default_nettype none
`include "ied_defines.svh"
module ied_dispatch_bench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  int          n_mismatch = 0, tests_run = 0, cyc = 0;
  // saved frame words, switch frame, dispatch table
  logic [31:0] fr [4] = '{32'h0000_0202, 32'h3, 32'h100, 32'h0000_E0E0};
  logic [31:0] sw [5] = '{32'h10, 32'h40, 32'h0000_0202, 32'h3, 32'h100};
  logic [31:0] tf [10] = '{32'h202, 32'h202, 32'hA02, 32'h202, 32'h202,
                           32'h202, 32'h202, 32'h002, 32'h202, 32'h202};
  logic [31:0] to [10] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h20, 32'h30,
                           32'h7FFF_FFF8, 32'h0, 32'h0, 32'h0};
  logic [31:0] tc [10] = '{32'h125, 32'h200, 32'h200, 32'h300, 32'h400,
                           32'h400, 32'h600, 32'h020, 32'h020, 32'h700};
  int          tv [10] = '{5, -1, 4, 3, -1, 5, -1, -1, 0, -1};
  // 20 MHz clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  ied_dispatch u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  // ***********************************************************************
  // bus tasks
  // ***********************************************************************
  task automatic end_sim();
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // request held until ready is sampled high at an edge
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) n_mismatch++;
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                     input logic [31:0] m = 32'hFFFF_FFFF);
    xfer(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask : rdc
  function automatic logic [7:0] sa(input int i);
    return `IED_OFF_STK + 8'(4 * i);
  endfunction : sa
  function automatic logic [31:0] go(input int i);
    return 32'h0100_0000 * i + 32'h0000_0400;
  endfunction : go
  task automatic gate(input int i, input logic [1:0] t, input logic [15:0] s);
    wr(`IED_OFF_GATE + 8'(8 * i), go(i));
    wr(`IED_OFF_GATE + 8'(8 * i + 4), {14'h0, t, s});
  endtask : gate
  // poll busy; a hang is cut short by the bound
  task automatic idle();
    int n;
    n = 0;
    do begin
      xfer(1'b0, `IED_OFF_CMD, 32'h0);
      n++;
    end while (rd[8] !== 1'b0 && n < 20);
    // a dispatch that never ends counts against the run
    if (rd[8] !== 1'b0) n_mismatch++;
  endtask : idle
  task automatic base();
    wr(`IED_OFF_FLAGS, 32'h0000_0202);
    wr(`IED_OFF_IP, 32'h100);
    wr(`IED_OFF_CS, 32'h3);
    wr(`IED_OFF_SP, 32'h40);
  endtask : base
  // hang guard, far above the several hundred cycles needed
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end
  // ***********************************************************************
  // scenarios
  // ***********************************************************************
  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rdc(`IED_OFF_FLAGS, `IED_RST_FLAGS);
    rdc(`IED_OFF_SP, 32'h0);
    xfer(1'b0, 8'h30, 32'h0);
    chk({31'h0, er}, 32'h1);
    xfer(1'b1, 8'h06, 32'h0);
    chk({31'h0, er}, 32'h1);
    for (int i = 0; i < 8; i++) gate(i, `IED_GT_TRAP, 16'h0003);
    // interrupt gate, same level, error code, write while busy
    wr(`IED_OFF_SS, 32'h10);
    wr(`IED_OFF_SP0, 32'h30);
    wr(`IED_OFF_SS0, 32'h20);
    wr(`IED_OFF_ERR, 32'h0000_E0E0);
    gate(6, `IED_GT_INT, 16'h0013);
    base();
    wr(`IED_OFF_CMD, 32'h0000_0806);
    wr(`IED_OFF_IP, 32'h0000_0BAD);
    chk({31'h0, er}, 32'h1);
    idle();
    for (int i = 0; i < 4; i++) rdc(sa(15 - i), fr[i]);
    rdc(`IED_OFF_SP, 32'h30);
    rdc(`IED_OFF_SS, 32'h10);
    rdc(`IED_OFF_FLAGS, 32'h2);
    rdc(`IED_OFF_CS, 32'h13);
    rdc(`IED_OFF_IP, go(6));
    rdc(`IED_OFF_CMD, 32'h6, 32'h0000_00FF);
    // same-level return, error code skipped by software
    wr(`IED_OFF_SP, 32'h34);
    wr(`IED_OFF_CMD, 32'h500);
    idle();
    rdc(`IED_OFF_FLAGS, 32'h202);
    rdc(`IED_OFF_IP, 32'h100);
    rdc(`IED_OFF_CS, 32'h3);
    rdc(`IED_OFF_SP, 32'h40);
    // trap gate to a more privileged level
    gate(1, `IED_GT_TRAP, 16'h0010);
    wr(`IED_OFF_CMD, 32'h1);
    idle();
    for (int i = 0; i < 5; i++) rdc(sa(11 - i), sw[i]);
    rdc(`IED_OFF_SS, 32'h20);
    rdc(`IED_OFF_SP, 32'h1C);
    rdc(`IED_OFF_FLAGS, 32'h202);
    // return across levels back to the old stack
    wr(`IED_OFF_CMD, 32'h500);
    idle();
    rdc(`IED_OFF_SS, 32'h10);
    rdc(`IED_OFF_SP, 32'h40);
    rdc(`IED_OFF_CS, 32'h3);
    rdc(`IED_OFF_FLAGS, 32'h202);
    // task gate and its return
    gate(2, `IED_GT_TASK, 16'h0033);
    wr(`IED_OFF_CMD, 32'h2);
    idle();
    rdc(`IED_OFF_CS, 32'h33);
    rdc(`IED_OFF_IP, go(2));
    rdc(`IED_OFF_FLAGS, 32'h4202);
    rdc(`IED_OFF_SP, 32'h40);
    wr(`IED_OFF_CMD, 32'h500);
    idle();
    rdc(`IED_OFF_CS, 32'h3);
    rdc(`IED_OFF_IP, 32'h100);
    rdc(`IED_OFF_FLAGS, 32'h202);
    // return to a more privileged level is refused
    wr(sa(9), 32'h0);
    wr(`IED_OFF_SP, 32'h20);
    wr(`IED_OFF_CMD, 32'h500);
    idle();
    rdc(`IED_OFF_CMD, 32'h800, 32'h0000_0800);
    rdc(`IED_OFF_CS, 32'h3);
    rdc(`IED_OFF_IP, 32'h100);
    // explicit instructions, events and arithmetic
    wr(`IED_OFF_BLO, 32'h10);
    wr(`IED_OFF_BHI, 32'h20);
    for (int i = 0; i < 10; i++) begin
      wr(`IED_OFF_FLAGS, tf[i]);
      wr(`IED_OFF_IP, 32'h100);
      wr(`IED_OFF_CS, 32'h3);
      wr(`IED_OFF_OPND, to[i]);
      wr(`IED_OFF_CMD, tc[i]);
      idle();
      // only the user vector with enable clear is held off
      rdc(`IED_OFF_CMD, {21'h0, i == 7, tv[i] >= 0, 9'h0},
          32'h0000_0600);
      rdc(`IED_OFF_IP, tv[i] < 0 ? 32'h100 : go(tv[i]));
      rdc(`IED_OFF_FLAGS, {20'h0, tf[i][11] | (tc[i][10:8] == 3'h6),
          11'h0}, 32'h0000_0800);
    end
    // real mode with error code
    base();
    wr(`IED_OFF_CMD, 32'h0000_1800);
    idle();
    for (int i = 0; i < 4; i++) rdc(sa(15 - i), fr[i]);
    rdc(`IED_OFF_IP, go(0));
    end_sim();
  end
endmodule : ied_dispatch_bench
`default_nettype wire

// File: dv/ied_dispatch_checker.sv
// Purpose: bus timing checks of the dispatcher
// Assumes: zero wait state slave, one clock domain
// Notes:   sees only the top ports
`timescale 1ns/1ps
`default_nettype none
module ied_dispatch_checker (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb request
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  // apb answer
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ***********************************************************************
  // transfer phases
  // ***********************************************************************
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_done;
    psel && penable && pready;
  endsequence
  // master waits for ready, so a late ready would stall software
  a_zero_wait: assert property (s_setup |=> s_done)
    else $error("access phase without ready");
  a_ready_once: assert property (pready |=> !pready)
    else $error("ready held past one cycle");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("ready outside access phase");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_rdata_quiet: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data not zero when idle");
  a_unaligned_err: assert property (
    s_setup and paddr[1:0] != 2'h0 |=> pslverr && prdata == 32'h0000_0000)
    else $error("unaligned access not refused");
  a_hole_err: assert property (
    s_setup and (paddr >= 8'h30 && paddr < 8'h40) |=> pslverr)
    else $error("unmapped access not refused");
  // reads of the stack window are always allowed
  a_stack_ok: assert property (s_setup and !pwrite
    and (paddr[7:6] == 2'b10 && paddr[1:0] == 2'h0) |=> !pslverr)
    else $error("stack read refused");
endmodule : ied_dispatch_checker
bind ied_dispatch ied_dispatch_checker u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr));
`default_nettype wire

// File: include/ied_defines.svh
// Purpose: offsets, field positions, reset values, codes of the dispatcher
// Assumes: 8-bit APB byte address, 32-bit words
// Notes:   definitions only
`ifndef IED_DEFINES_SVH
`define IED_DEFINES_SVH
// ***********************************************************************
// register byte offsets
// ***********************************************************************
`define IED_OFF_CMD     8'h00
`define IED_OFF_FLAGS   8'h04
`define IED_OFF_IP      8'h08
`define IED_OFF_CS      8'h0C
`define IED_OFF_SP      8'h10
`define IED_OFF_SS      8'h14
`define IED_OFF_ERR     8'h18
`define IED_OFF_SP0     8'h1C
`define IED_OFF_SS0     8'h20
`define IED_OFF_BLO     8'h24
`define IED_OFF_BHI     8'h28
`define IED_OFF_OPND    8'h2C
`define IED_OFF_GATE    8'h40
`define IED_GATE_STEP   8'h08
`define IED_OFF_STK     8'h80
// ***********************************************************************
// field positions and codes
// ***********************************************************************
`define IED_FLAG_IF     9
`define IED_FLAG_OF     11
`define IED_FLAG_NT     14
`define IED_CMD_OP_LSB  8
`define IED_CMD_ERR     11
`define IED_CMD_REAL    12
`define IED_GT_INT      2'h0
`define IED_GT_TRAP     2'h1
`define IED_GT_TASK     2'h2
`define IED_VEC_BP      8'h03
`define IED_VEC_OF      8'h04
`define IED_VEC_BR      8'h05
`define IED_VEC_USER    8'h20
`define IED_WORD_BYTES  32'h0000_0004
// ***********************************************************************
// reset values and frame indices
// ***********************************************************************
`define IED_RST_FLAGS   32'h0000_0002
`define IED_K_SS        3'h0
`define IED_K_SP        3'h1
`define IED_K_FLAGS     3'h2
`define IED_K_CS        3'h3
`define IED_K_IP        3'h4
`define IED_K_ERR       3'h5
`endif

// File: include/ied_pkg.sv
// Purpose: types of the exception dispatcher
// Assumes: constants come from ied_defines.svh
// Notes:   whole module state is one packed struct
package ied_pkg;
  // ***********************************************************************
  // enumerations
  // ***********************************************************************
  typedef enum logic [2:0] {
    IED_IDLE = 3'b001,
    IED_PUSH = 3'b010,
    IED_POP  = 3'b100
  } ied_state_t;

  typedef enum logic [2:0] {
    OP_EVENT = 3'h0,
    OP_SOFT  = 3'h1,
    OP_INTO  = 3'h2,
    OP_BREAK = 3'h3,
    OP_BOUND = 3'h4,
    OP_RETURN_FROM_INTERRUPT  = 3'h5,
    OP_ARITH = 3'h6,
    OP_NONE  = 3'h7
  } ied_op_t;

  // ***********************************************************************
  // module state
  // ***********************************************************************
  typedef struct packed {
    ied_state_t         st;
    logic [31:0]        flags, ip, cs, sp, ss, err;
    logic [31:0]        sp0, ss0, blo, bhi, opnd;
    logic [31:0]        oflags, oip, ocs, osp, oss;
    logic [31:0]        tflags, tip, tcs, tsp, tss;
    logic [7:0][31:0]   goff;
    logic [7:0][15:0]   gsel;
    logic [7:0][1:0]    gtyp;
    logic [15:0][31:0]  stk;
    logic [2:0]         k, kend;
    logic [7:0]         vec;
    logic               igate, raised, masked, fault;
    logic [31:0]        prdata;
    logic               pready, pslverr;
  } ied_regs_t;
endpackage : ied_pkg
